// File: core/ist_pkg.sv
// constants and carrier types for the i2c slave transmit engine
// assumes one system clock; bus pins arrive asynchronous to it
package ist_pkg;

   // ****************************************
   // counts, patterns and reset values
   // ****************************************
   localparam logic [3:0] BIT_CNT_RST   = 4'h0;
   localparam logic [3:0] BITS_IN_BYTE  = 4'h8;   // rises before the 8th falling edge
   localparam logic [3:0] BITS_WITH_ACK = 4'h9;   // rises before the 9th falling edge
   localparam logic [4:0] TEN_BIT_HDR   = 5'h1e;  // 1 1 1 1 0 in the high address byte
   localparam int         HDR_A9_POS    = 2;      // address bit nine in the address reg
   localparam int         HDR_A8_POS    = 1;      // address bit eight in the address reg
   localparam logic [7:0] BUF_RST       = 8'h00;
   localparam logic [7:0] ADDR_RST      = 8'h00;
   localparam logic [7:0] TX_RST        = 8'hff;  // released data line
   localparam logic       CKP_RST       = 1'b1;   // clock released after reset
   localparam int         SYNC_STAGES   = 2;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic ten_bit_mode;
      logic address_hold_enable;
      logic data_hold_enable;
      logic stretch_enable;
      logic start_int_enable;
      logic slave_collision_detect_enable;
      logic ack_value_to_send;     // 0 sends ACK, 1 sends NACK
   } ist_cfg_type;

   typedef struct packed {
      logic serial_event_flag;
      logic bus_collision_flag;
      logic buffer_full_flag;
      logic read_direction;
      logic start_seen;
      logic stop_seen;
      logic ack_received_status;
      logic ack_time_flag;
      logic address_update_flag;
      logic clock_release_bit;
   } ist_stat_type;

   typedef enum logic [6:0] {
      ST_IDLE  = 7'h01,
      ST_ADDR  = 7'h02,
      ST_ADDR2 = 7'h04,
      ST_ACK   = 7'h08,
      ST_RX    = 7'h10,
      ST_TX    = 7'h20,
      ST_TACK  = 7'h40
   } ist_state_type;

endpackage

// File: core/ist_pin_sync.sv
// two-stage synchroniser with edge detect for the bus pins
// assumes pins are asynchronous to mclk_in; reset is synchronous active high
`timescale 1ns/100ps
module ist_pin_sync (
   input  wire logic       mclk_in,
   input  wire logic       sys_rst_in,
   input  wire logic [1:0] pin_in,
   output logic      [1:0] level_out,
   output logic      [1:0] rise_out,
   output logic      [1:0] fall_out
);
   import ist_pkg::*;

   // ****************************************
   // per pin synchroniser and edge finder
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_pin
         logic [SYNC_STAGES-1:0] meta_r;
         logic                   last_r;
         // idle bus is high, so reset to high
         always_ff @(posedge mclk_in) begin
            if (sys_rst_in) begin
               meta_r <= '1;
               last_r <= 1'b1;
            end else begin
               meta_r <= {meta_r[SYNC_STAGES-2:0], pin_in[g]};
               last_r <= meta_r[SYNC_STAGES-1];
            end
         end
         assign level_out[g] = meta_r[SYNC_STAGES-1];
         assign rise_out[g]  = meta_r[SYNC_STAGES-1] & ~last_r;
         assign fall_out[g]  = ~meta_r[SYNC_STAGES-1] & last_r;
      end
   endgenerate

endmodule

// File: core/ist_slave.sv
// i2c slave engine: read path, 10-bit addressing, collision and stretching
// assumes bus pins outside the clock domain; software side on mclk_in
// Operation
// [R1] read match: direction set, buffer loaded, acked
// [R2] after read ack clear release bit, hold clock
// [R3] buffer write loads shifter; release bit frees clock
// [R4] data bits shift out on clock falling edges
// [R5] master ack latched on 9th rising edge
// [R6] nack ends transfer, idle until start
// [R7] after nack no hold, event still set
// [R8] event set per byte at 9th fall
// [R9] start sets start-seen, event if enabled
// [R10] collision while sending sets flag, goes idle
// [R11] address hold: release cleared, event at 8th
// [R12] address hold: send software ack value
// [R13] read ack or acked byte: clear release, event
// [R14] buffer write sets full, read clears it
// [R15] software loads data only after address ack
// [R16] master nacks last byte before stop
// [R17] 10-bit high write match sets update flag
// [R18] address write with update flag frees clock
// [R19] software updates address after ack sequence
// [R20] low mismatch: event and update, no full
// [R21] stretch enable: hold clock after each byte
// [R22] hold clock only once line seen low
// [R23] high byte matches 11110, A9, A8, 0
// [R24] any address write clears update flag; a write in the cycle of the 9th-fall set leaves it set
// [R25] hold enabled: ack-time flag at 8th fall
// [R26] collision: released high bit read back low
`timescale 1ns/100ps
module ist_slave (
   input  wire logic                mclk_in,
   input  wire logic                sys_rst_in,
   input  wire logic                scl_in,
   input  wire logic                sda_in,
   output logic                     scl_out,
   output logic                     scl_oe_out,
   output logic                     sda_out,
   output logic                     sda_oe_out,
   input  wire ist_pkg::ist_cfg_type cfg_in,
   input  wire logic                buf_wr_in,
   input  wire logic [7:0]          buf_wdata_in,
   input  wire logic                buf_rd_in,
   input  wire logic                addr_wr_in,
   input  wire logic [7:0]          addr_wdata_in,
   input  wire logic                ckp_set_in,
   input  wire logic                event_clr_in,
   input  wire logic                collision_clr_in,
   output logic      [7:0]          buf_rdata_out,
   output logic      [7:0]          slave_address_out,
   output ist_pkg::ist_stat_type    status_out
);
   import ist_pkg::*;

   // ****************************************
   // pin sampling
   // ****************************************
   logic [1:0] lvl;
   logic [1:0] rise;
   logic [1:0] fall;

   ist_pin_sync u_sync (
      .mclk_in   (mclk_in),
      .sys_rst_in(sys_rst_in),
      .pin_in    ({sda_in, scl_in}),
      .level_out (lvl),
      .rise_out  (rise),
      .fall_out  (fall)
   );

   logic scl_lvl;
   logic sda_lvl;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   assign scl_lvl   = lvl[0];
   assign sda_lvl   = lvl[1];
   assign scl_rise  = rise[0];
   assign scl_fall  = fall[0];
   assign start_det = fall[1] & scl_lvl;
   assign stop_det  = rise[1] & scl_lvl;

   // ****************************************
   // state and storage
   // ****************************************
   ist_state_type state_r;
   ist_state_type ack_to_r;
   logic [3:0]    cnt_r;
   logic [7:0]    sr_r;
   logic [7:0]    tx_r;
   logic [7:0]    buf_r;
   logic [7:0]    addr_r;
   logic          ack_ok_r;
   logic          hold_byte_r;
   logic          ua_pend_r;
   logic          lo_ok_r;
   logic          hold_r;
   logic          sda_oe_r;
   logic          sef_r;
   logic          bcl_r;
   logic          bf_r;
   logic          dir_r;
   logic          s_r;
   logic          p_r;
   logic          ack_received_status_r;
   logic          ack_time_flag_r;
   logic          ua_r;
   logic          ckp_r;

   // high address byte compare, used for write and read headers
   function automatic logic hdr_ok(input logic [7:0] b, input logic [7:0] a);
      hdr_ok = (b[7:3] == TEN_BIT_HDR) && (b[2] == a[HDR_A9_POS])
               && (b[1] == a[HDR_A8_POS]);
   endfunction

   // ****************************************
   // byte timing events
   // ****************************************
   logic fall8;
   logic fall9;
   logic rise9;
   logic in_tx;
   logic in_ack;
   assign fall8  = scl_fall & (cnt_r == BITS_IN_BYTE);
   assign fall9  = scl_fall & (cnt_r == BITS_WITH_ACK);
   assign rise9  = scl_rise & (cnt_r == BITS_IN_BYTE);
   assign in_tx  = (state_r == ST_TX);
   assign in_ack = (state_r == ST_ACK);

   // address decisions at the 8th falling edge
   logic hdr_wr;
   logic hdr_rd;
   logic hit7;
   logic addr_hit;
   logic lo_hit;
   assign hdr_wr = cfg_in.ten_bit_mode & hdr_ok(sr_r, addr_r) & ~sr_r[0];   // [R23]
   assign hdr_rd = cfg_in.ten_bit_mode & hdr_ok(sr_r, addr_r) & sr_r[0] & lo_ok_r;
   assign hit7   = ~cfg_in.ten_bit_mode & (sr_r[7:1] == addr_r[7:1]);
   assign addr_hit = (state_r == ST_ADDR) & fall8 & (hdr_wr | hdr_rd | hit7);
   assign lo_hit = (sr_r == addr_r);

   // collision: our released bit is read back low while clock rises
   logic collide;
   assign collide = in_tx & scl_rise & tx_r[7] & ~sda_lvl
                    & cfg_in.slave_collision_detect_enable;           // [R26]

   // ack actually driven in the ack slot
   logic ack_given;
   assign ack_given = hold_byte_r ? ~cfg_in.ack_value_to_send : ack_ok_r;

   // ****************************************
   // bit counter and receive shifter
   // ****************************************
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in | start_det | stop_det) begin
         cnt_r <= BIT_CNT_RST;
      end else if (fall9) begin
         cnt_r <= BIT_CNT_RST;
      end else if (scl_rise & (state_r != ST_IDLE)) begin
         cnt_r <= cnt_r + 4'h1;
      end
   end

   // data sampled on rising clock edges
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         sr_r <= BUF_RST;
      end else if (scl_rise) begin
         sr_r <= {sr_r[6:0], sda_lvl};
      end
   end

   // ****************************************
   // sequencing
   // ****************************************
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         state_r     <= ST_IDLE;
         ack_to_r    <= ST_IDLE;
         ack_ok_r    <= 1'b0;
         hold_byte_r <= 1'b0;
         ua_pend_r   <= 1'b0;
      end else if (start_det) begin
         state_r <= ST_ADDR;
      end else if (stop_det | collide) begin
         state_r <= ST_IDLE;                                           // [R10]
      end else begin
         case (state_r)
            ST_IDLE: begin
               state_r <= ST_IDLE;
            end
            ST_ADDR: begin
               if (fall8) begin
                  state_r     <= addr_hit ? ST_ACK : ST_IDLE;
                  ack_to_r    <= sr_r[0] ? ST_TX : (hdr_wr ? ST_ADDR2 : ST_RX);
                  ack_ok_r    <= 1'b1;                                 // [R1]
                  hold_byte_r <= cfg_in.address_hold_enable;
                  ua_pend_r   <= hdr_wr;                               // [R17]
               end
            end
            ST_ADDR2: begin
               if (fall8) begin
                  state_r     <= ST_ACK;
                  ack_to_r    <= lo_hit ? ST_RX : ST_IDLE;
                  ack_ok_r    <= lo_hit;
                  hold_byte_r <= lo_hit & cfg_in.address_hold_enable;
                  ua_pend_r   <= 1'b1;                                 // [R20]
               end
            end
            ST_RX: begin
               if (fall8) begin
                  state_r     <= ST_ACK;
                  ack_to_r    <= ST_RX;
                  ack_ok_r    <= ~bf_r;
                  hold_byte_r <= cfg_in.data_hold_enable;
                  ua_pend_r   <= 1'b0;
               end
            end
            ST_ACK: begin
               if (fall9) begin
                  state_r <= (ack_given | ua_pend_r) ? ack_to_r : ST_IDLE;
               end
            end
            ST_TX: begin
               if (fall8) begin
                  state_r <= ST_TACK;
               end
            end
            ST_TACK: begin
               if (fall9) begin
                  state_r <= ack_received_status_r ? ST_IDLE : ST_TX;              // [R6]
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // data line drive
   // ****************************************
   // ack waits for the released clock when software chooses it
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         sda_oe_r <= 1'b0;
      end else if (in_ack) begin
         sda_oe_r <= hold_byte_r ? (ckp_r & ~cfg_in.ack_value_to_send)  // [R12]
                                 : ack_ok_r;
      end else if (in_tx) begin
         sda_oe_r <= ~tx_r[7];                                          // [R4]
      end else begin
         sda_oe_r <= 1'b0;
      end
   end

   // transmit shifter; a buffer write loads it directly
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         tx_r <= TX_RST;
      end else if (buf_wr_in) begin
         tx_r <= buf_wdata_in;                                          // [R3]
      end else if (in_tx & scl_fall & (cnt_r != BIT_CNT_RST)) begin
         tx_r <= {tx_r[6:0], 1'b1};                                     // [R4]
      end
   end

   // ****************************************
   // clock stretching
   // ****************************************
   logic need_hold;
   assign need_hold = ua_r | (~ckp_r & (state_r != ST_IDLE));

   // grab the line only after the master has pulled it low
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         hold_r <= 1'b0;
      end else if (~need_hold) begin
         hold_r <= 1'b0;                                                // [R22]
      end else if (~scl_lvl) begin
         hold_r <= 1'b1;                                                // [R22]
      end
   end

   // release bit: hardware clears, a software set wins
   logic ckp_clr;
   assign ckp_clr = (addr_hit & cfg_in.address_hold_enable)             // [R11]
                  | ((state_r == ST_RX) & fall8 & cfg_in.data_hold_enable)
                  | (in_ack & fall9 & ack_given & (ack_to_r == ST_TX))  // [R2]
                  | (in_ack & fall9 & ack_given & (ack_to_r == ST_RX)
                     & cfg_in.stretch_enable)                           // [R21]
                  | ((state_r == ST_TACK) & fall9 & ~ack_received_status_r);        // [R13]

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         ckp_r <= CKP_RST;
      end else if (ckp_set_in) begin
         ckp_r <= 1'b1;                                                 // [R3]
      end else if (ckp_clr) begin
         ckp_r <= 1'b0;
      end
   end

   // ****************************************
   // address register and update flag
   // ****************************************
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         addr_r <= ADDR_RST;
      end else if (addr_wr_in) begin
         addr_r <= addr_wdata_in;
      end
   end

   // set at the 9th fall wins over the clearing write
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         ua_r <= 1'b0;
      end else if (in_ack & fall9 & ua_pend_r) begin
         ua_r <= 1'b1;                                                  // [R17]
      end else if (addr_wr_in) begin
         ua_r <= 1'b0;                                                  // [R18] [R24]
      end
   end

   // full high and low 10-bit match allows a later read header
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in | stop_det) begin
         lo_ok_r <= 1'b0;
      end else if (addr_hit & hdr_wr) begin
         lo_ok_r <= 1'b0;
      end else if ((state_r == ST_ADDR2) & fall8) begin
         lo_ok_r <= lo_hit;
      end
   end

   // ****************************************
   // data buffer and full flag
   // ****************************************
   logic hw_load;
   assign hw_load = addr_hit
                  | ((state_r == ST_ADDR2) & fall8 & lo_hit)
                  | ((state_r == ST_RX) & fall8 & ~bf_r);

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         buf_r <= BUF_RST;
      end else if (hw_load) begin
         buf_r <= sr_r;                                                 // [R1]
      end else if (buf_wr_in) begin
         buf_r <= buf_wdata_in;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         bf_r <= 1'b0;
      end else if (hw_load | buf_wr_in) begin
         bf_r <= 1'b1;                                                  // [R14]
      end else if (buf_rd_in) begin
         bf_r <= 1'b0;                                                  // [R14]
      end
   end

   // ****************************************
   // status bits
   // ****************************************
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         dir_r <= 1'b0;
      end else if (addr_hit) begin
         dir_r <= sr_r[0];                                              // [R1]
      end
   end

   // start and stop seen, each clearing the other
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         s_r <= 1'b0;
         p_r <= 1'b0;
      end else if (start_det) begin
         s_r <= 1'b1;                                                   // [R9]
         p_r <= 1'b0;
      end else if (stop_det) begin
         s_r <= 1'b0;
         p_r <= 1'b1;
      end
   end

   // master acknowledge taken on the 9th rising edge while sending
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         ack_received_status_r <= 1'b0;
      end else if ((state_r == ST_TACK) & rise9) begin
         ack_received_status_r <= sda_lvl;                                          // [R5]
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         ack_time_flag_r <= 1'b0;
      end else if ((addr_hit | ((state_r == ST_RX) & fall8))
                   & (cfg_in.address_hold_enable | cfg_in.data_hold_enable)) begin
         ack_time_flag_r <= 1'b1;                                              // [R25]
      end else if (fall9) begin
         ack_time_flag_r <= 1'b0;
      end
   end

   // ****************************************
   // event and collision flags, set wins over clear
   // ****************************************
   logic sef_set;
   assign sef_set = (start_det & cfg_in.start_int_enable)               // [R9]
                  | (addr_hit & cfg_in.address_hold_enable)             // [R11]
                  | ((state_r == ST_RX) & fall8 & cfg_in.data_hold_enable)
                  | (in_ack & fall9 & (ack_given | ua_pend_r))          // [R8] [R13] [R20]
                  | ((state_r == ST_TACK) & fall9);                     // [R7] [R8]

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         sef_r <= 1'b0;
      end else if (sef_set) begin
         sef_r <= 1'b1;
      end else if (event_clr_in) begin
         sef_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         bcl_r <= 1'b0;
      end else if (collide) begin
         bcl_r <= 1'b1;                                                 // [R10]
      end else if (collision_clr_in) begin
         bcl_r <= 1'b0;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign scl_out           = 1'b0;   // open drain: only ever pulls low
   assign sda_out           = 1'b0;
   assign scl_oe_out        = hold_r;
   assign sda_oe_out        = sda_oe_r;
   assign buf_rdata_out     = buf_r;
   assign slave_address_out = addr_r;
   assign status_out        = '{serial_event_flag:   sef_r,
                                bus_collision_flag:  bcl_r,
                                buffer_full_flag:    bf_r,
                                read_direction:      dir_r,
                                start_seen:          s_r,
                                stop_seen:           p_r,
                                ack_received_status: ack_received_status_r,
                                ack_time_flag:       ack_time_flag_r,
                                address_update_flag: ua_r,
                                clock_release_bit:   ckp_r};

endmodule

// File: tb/ist_slave_props.sv
// checker for the i2c slave engine, ports only
// bound to ist_slave from the bench top file
`timescale 1ns/100ps
module ist_slave_props (
   input wire logic                 mclk_in,
   input wire logic                 sys_rst_in,
   input wire logic                 scl_in,
   input wire logic                 scl_oe_out,
   input wire logic                 sda_oe_out,
   input wire ist_pkg::ist_cfg_type  cfg_in,
   input wire logic                 buf_wr_in,
   input wire logic [7:0]           buf_wdata_in,
   input wire logic                 addr_wr_in,
   input wire logic [7:0]           addr_wdata_in,
   input wire logic                 ckp_set_in,
   input wire logic                 event_clr_in,
   input wire logic [7:0]           buf_rdata_out,
   input wire logic [7:0]           slave_address_out,
   input wire ist_pkg::ist_stat_type status_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   // line let go soon after release
   sequence s_scl_free;
      ##[0:2] !scl_oe_out;
   endsequence
   sequence s_sda_free;
      ##[0:1] !sda_oe_out;
   endsequence
   property p_hold_low;
      $rose(scl_oe_out) |-> !$past(scl_in);
   endproperty
   a_hold_low: assert property (p_hold_low) else $error("clock pulled high");
   property p_ckp;
      ckp_set_in |=> status_out.clock_release_bit;
   endproperty
   a_ckp: assert property (p_ckp) else $error("release bit not set");
   property p_free;
      $rose(status_out.clock_release_bit) && !status_out.address_update_flag |-> s_scl_free;
   endproperty
   a_free: assert property (p_free) else $error("clock not released");
   property p_full;
      buf_wr_in |=> status_out.buffer_full_flag && buf_rdata_out == $past(buf_wdata_in);
   endproperty
   a_full: assert property (p_full) else $error("buffer write lost");
   property p_addr;
      addr_wr_in |=> !status_out.address_update_flag
         && slave_address_out == $past(addr_wdata_in);
   endproperty
   a_addr: assert property (p_addr) else $error("address write wrong");
   property p_evt_clr;
      $fell(status_out.serial_event_flag) |-> $past(event_clr_in);
   endproperty
   a_evt_clr: assert property (p_evt_clr) else $error("event dropped alone");
   property p_evt_fall;
      $rose(status_out.serial_event_flag) |-> !scl_in || $rose(status_out.start_seen);
   endproperty
   a_evt_fall: assert property (p_evt_fall) else $error("event off clock low");
   property p_ack_received_status;
      $changed(status_out.ack_received_status) |-> scl_in && !$past(scl_in, 8);
   endproperty
   a_ack_received_status: assert property (p_ack_received_status) else $error("ack latched off rise");
   property p_coll;
      $rose(status_out.bus_collision_flag) |->
         cfg_in.slave_collision_detect_enable ##0 s_sda_free;
   endproperty
   a_coll: assert property (p_coll) else $error("collision wrong");
endmodule

// File: tb/ist_bus_master.sv
// bus master model: open-drain pulls, clock 125 ns
// assumes the bench resolves the wires; tasks start on a falling clock edge
`timescale 1ns/100ps
module ist_bus_master (
   input  wire logic mclk_in,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      scl_low_out = 1'b0,
   output logic      sda_low_out = 1'b0
);
   task automatic wt(input int n);
      repeat (n) @(negedge mclk_in);
   endtask
   // release clock, wait out stretch
   task automatic up();
      scl_low_out = 1'b0;
      wait (scl_in);
      wt(1);
   endtask
   // start (s=1) or stop (s=0): data moves while clock is high
   task automatic cond(input logic s);
      sda_low_out = !s;
      wt(6);
      up();
      wt(12);
      sda_low_out = s;
      wt(12);
      scl_low_out = s;
      if (s) wt(6);
   endtask
   // n bits of d, msb first, wire sampled
   task automatic bits(input logic [8:0] d, input int n, output logic [8:0] r);
      r = 9'h000;
      for (int i = 0; i < n; i++) begin
         sda_low_out = !d[8-i];
         wt(6);
         up();
         wt(5);
         r = {r[7:0], sda_in};
         wt(7);
         scl_low_out = 1'b1;
         wt(6);
      end
      wt(6);
   endtask
endmodule

// File: tb/test_ist_slave.sv
// self-checking bench for the i2c slave engine
// inputs change on the falling clock edge
`timescale 1ns/100ps
module test_ist_slave;
   import ist_pkg::*;
   logic mclk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   ist_cfg_type cfg = '0;
   logic [5:0] pl = 6'h00;
   logic [7:0] wdata = 8'h00;
   logic scl_oe, sda_oe, scl_low, sda_low, scl, sda;
   logic [7:0] rdata, saddr;
   ist_stat_type st;
   logic [8:0] r;
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;
   assign scl = ~(scl_oe | scl_low);
   assign sda = ~(sda_oe | sda_low);
   always #2.5 mclk_in = ~mclk_in;
   ist_slave dut_u (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda),
      .scl_out(), .scl_oe_out(scl_oe), .sda_out(), .sda_oe_out(sda_oe), .cfg_in(cfg),
      .buf_wr_in(pl[0]), .buf_wdata_in(wdata), .buf_rd_in(pl[1]), .addr_wr_in(pl[2]),
      .addr_wdata_in(wdata), .ckp_set_in(pl[3]), .event_clr_in(pl[4]),
      .collision_clr_in(pl[5]), .buf_rdata_out(rdata), .slave_address_out(saddr),
      .status_out(st));
   ist_bus_master bm (.mclk_in(mclk_in), .scl_in(scl), .sda_in(sda),
      .scl_low_out(scl_low), .sda_low_out(sda_low));
   // pulse k: 0 buf wr, 1 buf rd, 2 addr, 3 release, 4 event clr, 5 collision clr
   task automatic sw(input int k, input logic [7:0] d = 8'h00);
      @(negedge mclk_in);
      wdata = d;
      pl = 6'h01 << k;
      @(negedge mclk_in);
      pl = 6'h00;
      @(negedge mclk_in);
   endtask
   task automatic chk(input logic [10:0] g, input logic [10:0] e);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wrap_up();
      $display("mismatches %0d of %0d compared", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   initial begin
      repeat (6) @(negedge mclk_in);
      sys_rst_in = 1'b0;
      repeat (3) @(negedge mclk_in);
      chk(st, 10'h001);
      chk(rdata, 8'h00);
      // 7-bit read with ack then nack
      cfg.start_int_enable = 1'b1;
      sw(2, 8'ha4);
      bm.cond(1'b1);
      chk({st.start_seen, st.serial_event_flag}, 2'h3);
      sw(4);
      bm.bits({8'ha5, 1'b1}, 9, r);
      chk({r[0], rdata, st.read_direction, st.buffer_full_flag}, 11'h297);
      chk({st.serial_event_flag, st.clock_release_bit, scl_oe}, 3'h5);
      sw(4);
      sw(1);
      chk(st.buffer_full_flag, 1'b0);
      sw(0, 8'h3c);
      chk(st.buffer_full_flag, 1'b1);
      sw(3);
      bm.bits({8'hff, 1'b0}, 9, r);
      chk(r[8:1], 8'h3c);
      chk({st.ack_received_status, st.serial_event_flag, st.clock_release_bit}, 3'h2);
      sw(4);
      sw(0, 8'hc3);
      sw(3);
      bm.bits({8'hff, 1'b1}, 9, r);
      chk(r[8:1], 8'hc3);
      chk({st.ack_received_status, st.serial_event_flag, scl_oe}, 3'h6);
      bm.bits({8'ha5, 1'b1}, 9, r);
      chk(r[0], 1'b1);
      bm.cond(1'b0);
      // address hold, then a collision
      cfg = '0;
      cfg.address_hold_enable = 1'b1;
      cfg.slave_collision_detect_enable = 1'b1;
      sw(4);
      bm.cond(1'b1);
      bm.bits({8'ha5, 1'b1}, 8, r);
      chk({st.serial_event_flag, st.clock_release_bit, scl_oe}, 3'h5);
      chk(st.ack_time_flag, 1'b1);
      sw(4);
      sw(1);
      sw(3);
      bm.bits(9'h100, 1, r);
      chk({r[0], st.serial_event_flag, st.clock_release_bit}, 3'h2);
      sw(4);
      sw(0, 8'h7f);
      sw(3);
      bm.bits(9'h000, 2, r);
      chk({st.bus_collision_flag, sda_oe}, 2'h2);
      bm.cond(1'b0);
      sw(5);
      chk(st.bus_collision_flag, 1'b0);
      // 10-bit header, low byte miss
      cfg = '0;
      cfg.ten_bit_mode = 1'b1;
      sw(4);
      sw(2, 8'h06);
      bm.cond(1'b1);
      bm.bits({8'hf6, 1'b1}, 9, r);
      chk({r[0], st.address_update_flag, st.serial_event_flag, scl_oe}, 4'h7);
      sw(1);
      sw(4);
      sw(2, 8'h5a);
      chk({st.address_update_flag, scl_oe}, 2'h0);
      bm.bits({8'h33, 1'b1}, 9, r);
      chk({r[0], st.serial_event_flag, st.address_update_flag}, 3'h7);
      chk({st.buffer_full_flag, st.clock_release_bit}, 2'h1);
      sw(2, 8'h06);
      chk(scl_oe, 1'b0);
      bm.cond(1'b0);
      wrap_up();
   end
endmodule
bind ist_slave ist_slave_props u_props (.mclk_in, .sys_rst_in, .scl_in, .scl_oe_out,
   .sda_oe_out, .cfg_in, .buf_wr_in, .buf_wdata_in, .addr_wr_in, .addr_wdata_in,
   .ckp_set_in, .event_clr_in, .buf_rdata_out, .slave_address_out, .status_out);
